// ### hw/dud_defs.vh
// Constants for the data unit opcode decoder: field positions, format codes,
// address modes, AXI4-Lite register offsets, reset values.
// Assumes a single 25 MHz core clock and a synchronous active-low reset.
//
// Summary of operation
// - Bit 0 is the parallel-chain flag; 1 means next instruction issues alongside.
// - Bits 31-29 select the condition register; bit 28 is the zero-test flag.
// - Zero-test flag 1 runs on register equal zero, 0 on nonzero.
// - Side bit picks file A (0) or B (1); load/store: base pointer side.
// - Cross-path bit 0 reads second source locally, 1 from the opposite file.
// - Load/store bit 7 picks first (0) or second (1) data unit.
// - Compact forms address registers as offsets from register 16 of the side's file; the decoder decodes no compact forms.
// - Basic load/store field layout, recognised by bits 3-2 equal 01.
// - Long-immediate load/store: 15-bit offset at 22-8, bits 3-2 equal 11.
// - Basic data unit format: operation at 12-7, bits 6-2 equal 10000.
// - Extended data unit: cross at 12, bits 11-10 equal 10, op 9-6, 5-2 equal 1100.
// - Modes 0000/0001/0100/0101 offset base by constant or register, no update.
// - Modes 1000-1011 pre/post decrement/increment by constant, base updated.
// - Modes 1100-1111 pre/post decrement/increment by register, base updated.
// - Long-immediate byte, halfword, word accesses only legal on the second data unit.
// - Register branch, return-pointer branch, control move only on second shift unit.
// - Integer multiply, doubleword load and floating-point ops are supported.
// - Enhanced variant routes float add and subtract to shift units too.
`ifndef DUD_DEFS_VH
`define DUD_DEFS_VH

// Common fields
`define DUD_CREG_HI 31
`define DUD_CREG_LO 29
`define DUD_Z_BIT 28
`define DUD_DST_HI 27
`define DUD_DST_LO 23
`define DUD_SECOND_OPERAND_FIELD_HI 22
`define DUD_SECOND_OPERAND_FIELD_LO 18
`define DUD_FIRST_OPERAND_FIELD_HI 17
`define DUD_FIRST_OPERAND_FIELD_LO 13
`define DUD_X_BIT 12
`define DUD_S_BIT 1
`define DUD_P_BIT 0

// Load/store fields
`define DUD_MODE_HI 12
`define DUD_MODE_LO 9
`define DUD_R_BIT 8
`define DUD_Y_BIT 7
`define DUD_LSOP_HI 6
`define DUD_LSOP_LO 4
`define DUD_LIMM_HI 22
`define DUD_LIMM_LO 8

// Format recognition codes
`define DUD_LS_BASIC 2'h1
`define DUD_LS_LONG 2'h3
`define DUD_D_BASIC 5'h10
`define DUD_D_EXT 4'hC
`define DUD_D_EXT_FIX 2'h2
`define DUD_COMPACT_BASE 5'h10

// Address modes
`define DUD_MODE_NCST 4'h0
`define DUD_MODE_PCST 4'h1
`define DUD_MODE_NREG 4'h4
`define DUD_MODE_PREG 4'h5

// Format codes reported
`define DUD_FMT_NONE 3'h0
`define DUD_FMT_LS_BASIC 3'h1
`define DUD_FMT_LS_LONG 3'h2
`define DUD_FMT_D_BASIC 3'h3
`define DUD_FMT_D_EXT 3'h4

// Register offsets (byte addresses)
`define DUD_REG_INSN 8'h00
`define DUD_REG_CTRL 8'h04
`define DUD_REG_FIELDS 8'h08
`define DUD_REG_STATUS 8'h0C
`define DUD_REG_ADDR 8'h10
`define DUD_REG_BASE 8'h14

// Reset values
`define DUD_CTRL_RST 32'h0000_0000

`endif

// ### hw/dud_decoder.v
// Data unit opcode decoder with an AXI4-Lite register slave.
// Assumes fetch presents one word per cycle with a valid strobe and that the
// register files supply base, offset and predicate values combinationally.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "dud_defs.vh"

module dud_decoder
#(
  parameter ADDR_W = 32
)
(
  input wire core_clk_i,
  input wire rst_n_i,
  // Instruction in
  input wire insn_valid_i,
  input wire [31:0] insn_i,
  input wire enhanced_i,
  input wire [31:0] pred_value_i,
  input wire [ADDR_W-1:0] base_value_i,
  input wire [ADDR_W-1:0] index_value_i,
  // Decoded fields
  output reg dec_valid_o,
  output reg [2:0] dec_format_o,
  output reg [2:0] cond_sel_o,
  output reg zero_test_o,
  output reg execute_o,
  output reg parallel_o,
  output reg side_b_o,
  output reg cross_path_o,
  output reg second_data_unit_o,
  output reg [5:0] operation_field_o,
  output reg [4:0] dest_reg_o,
  output reg [4:0] pointer_reg_field_o,
  output reg [4:0] index_reg_field_o,
  output reg doubleword_o,
  output reg illegal_o,
  // Address generation
  output reg [ADDR_W-1:0] mem_addr_o,
  output reg base_wb_o,
  output reg [ADDR_W-1:0] base_wb_value_o,
  // Unit routing checks
  input wire [4:0] class_i,
  output reg route_ok_o,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
// Instruction classes for unit routing
localparam [4:0] CL_LS_LONG = 5'h01;
localparam [4:0] CL_BR_REG = 5'h02;
localparam [4:0] CL_BR_RET = 5'h03;
localparam [4:0] CL_CTRL_MOVE = 5'h04;
localparam [4:0] CL_FADD_S = 5'h05;
localparam [4:0] CL_INT_MUL = 5'h06;
localparam [4:0] CL_DW_LOAD = 5'h07;
localparam [4:0] CL_FLOAT = 5'h08;
localparam [4:0] CL_S2_UNIT = 5'h10;

// Picks the predicate register bit that the condition selector names
function cond_true;
  input [2:0] sel;
  input z;
  input [31:0] vals;
  reg nz;
  begin
    nz = vals[sel];
    if (sel == 3'h0)
    begin
      cond_true = 1'b1;
    end
    else
    begin
      cond_true = z ? ~nz : nz;
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Control register: bit0 forces enhanced, bit1 freezes capture
reg [31:0] ctrl_reg;
reg [31:0] last_insn_reg;
reg [31:0] decode_cnt_reg;
reg [31:0] illegal_cnt_reg;
wire enh = enhanced_i | ctrl_reg[0];

// Combinational decode
reg [2:0] fmt_next;
reg illegal_next;
reg [5:0] opf_next;
reg [3:0] mode;
reg [ADDR_W-1:0] offs;
reg [ADDR_W-1:0] sum_addr;
reg [ADDR_W-1:0] mem_next;
reg wb_next;
reg route_next;
reg [4:0] dst_next;
always @*
begin
  fmt_next = `DUD_FMT_NONE;
  illegal_next = 1'b0;
  opf_next = 6'h00;
  mode = insn_i[`DUD_MODE_HI:`DUD_MODE_LO];
  offs = {ADDR_W{1'b0}};
  sum_addr = base_value_i;
  mem_next = base_value_i;
  wb_next = 1'b0;
  dst_next = insn_i[`DUD_DST_HI:`DUD_DST_LO];
  if (insn_i[3:2] == `DUD_LS_LONG)
  begin
    fmt_next = `DUD_FMT_LS_LONG;
    opf_next = {3'h0, insn_i[`DUD_LSOP_HI:`DUD_LSOP_LO]};
    offs = {{(ADDR_W-15){1'b0}}, insn_i[`DUD_LIMM_HI:`DUD_LIMM_LO]};
    mem_next = base_value_i + offs;
    illegal_next = ~insn_i[`DUD_Y_BIT];
  end
  else if (insn_i[3:2] == `DUD_LS_BASIC)
  begin
    fmt_next = `DUD_FMT_LS_BASIC;
    opf_next = {3'h0, insn_i[`DUD_LSOP_HI:`DUD_LSOP_LO]};
    // Constant or register offset
    if (mode[2])
    begin
      offs = index_value_i;
    end
    else
    begin
      offs = {{(ADDR_W-5){1'b0}}, insn_i[`DUD_FIRST_OPERAND_FIELD_HI:`DUD_FIRST_OPERAND_FIELD_LO]};
    end
    sum_addr = mode[0] ? base_value_i + offs : base_value_i - offs;
    if (!mode[3])
    begin
      if (mode[1])
      begin
        illegal_next = 1'b1;
      end
      else
      begin
        mem_next = sum_addr;
      end
    end
    else
    begin
      wb_next = 1'b1;
      mem_next = mode[1] ? base_value_i : sum_addr;
    end
  end
  else if (insn_i[6:2] == `DUD_D_BASIC)
  begin
    fmt_next = `DUD_FMT_D_BASIC;
    opf_next = insn_i[12:7];
  end
  else if (insn_i[5:2] == `DUD_D_EXT)
  begin
    fmt_next = `DUD_FMT_D_EXT;
    opf_next = {2'h0, insn_i[9:6]};
    illegal_next = (insn_i[11:10] != `DUD_D_EXT_FIX);
  end
  else
  begin
    illegal_next = 1'b1;
  end
end

// Unit routing legality
always @*
begin
  case (class_i)
    CL_BR_REG, CL_BR_RET, CL_CTRL_MOVE: route_next = class_i[4] | 1'b0;
    CL_BR_REG | CL_S2_UNIT, CL_BR_RET | CL_S2_UNIT,
    CL_CTRL_MOVE | CL_S2_UNIT: route_next = 1'b1;
    CL_FADD_S, CL_FADD_S | CL_S2_UNIT: route_next = enh;
    CL_INT_MUL, CL_DW_LOAD, CL_FLOAT: route_next = 1'b1;
    CL_LS_LONG: route_next = 1'b0;
    CL_LS_LONG | CL_S2_UNIT: route_next = 1'b1;
    default: route_next = 1'b1;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// Decode output register
always @(posedge core_clk_i)
begin
  if (!rst_n_i)
  begin
    dec_valid_o <= 1'b0;
    dec_format_o <= 3'h0;
    cond_sel_o <= 3'h0;
    zero_test_o <= 1'b0;
    execute_o <= 1'b0;
    parallel_o <= 1'b0;
    side_b_o <= 1'b0;
    cross_path_o <= 1'b0;
    second_data_unit_o <= 1'b0;
    operation_field_o <= 6'h00;
    dest_reg_o <= 5'h00;
    pointer_reg_field_o <= 5'h00;
    index_reg_field_o <= 5'h00;
    doubleword_o <= 1'b0;
    illegal_o <= 1'b0;
    mem_addr_o <= {ADDR_W{1'b0}};
    base_wb_o <= 1'b0;
    base_wb_value_o <= {ADDR_W{1'b0}};
    route_ok_o <= 1'b0;
  end
  else
  begin
    dec_valid_o <= insn_valid_i;
    dec_format_o <= fmt_next;
    cond_sel_o <= insn_i[`DUD_CREG_HI:`DUD_CREG_LO];
    zero_test_o <= insn_i[`DUD_Z_BIT];
    execute_o <= insn_valid_i & ~illegal_next
      & cond_true(insn_i[`DUD_CREG_HI:`DUD_CREG_LO], insn_i[`DUD_Z_BIT],
      pred_value_i);
    parallel_o <= insn_i[`DUD_P_BIT];
    side_b_o <= insn_i[`DUD_S_BIT];
    cross_path_o <= (fmt_next == `DUD_FMT_D_EXT) & insn_i[`DUD_X_BIT];
    second_data_unit_o <= insn_i[`DUD_Y_BIT];
    operation_field_o <= opf_next;
    dest_reg_o <= dst_next;
    pointer_reg_field_o <= insn_i[`DUD_SECOND_OPERAND_FIELD_HI:`DUD_SECOND_OPERAND_FIELD_LO];
    index_reg_field_o <= insn_i[`DUD_FIRST_OPERAND_FIELD_HI:`DUD_FIRST_OPERAND_FIELD_LO];
    doubleword_o <= (fmt_next == `DUD_FMT_LS_BASIC) & insn_i[`DUD_R_BIT];
    illegal_o <= insn_valid_i & illegal_next;
    mem_addr_o <= mem_next;
    base_wb_o <= insn_valid_i & wb_next;
    base_wb_value_o <= sum_addr;
    route_ok_o <= route_next;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Capture and counters for software view
always @(posedge core_clk_i)
begin
  if (!rst_n_i)
  begin
    last_insn_reg <= 32'h0000_0000;
    decode_cnt_reg <= 32'h0000_0000;
    illegal_cnt_reg <= 32'h0000_0000;
  end
  else if (insn_valid_i && !ctrl_reg[1])
  begin
    last_insn_reg <= insn_i;
    decode_cnt_reg <= decode_cnt_reg + 32'h0000_0001;
    if (illegal_next)
    begin
      illegal_cnt_reg <= illegal_cnt_reg + 32'h0000_0001;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write path: address and data taken in either order
reg aw_held;
reg w_held;
reg [7:0] aw_addr_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready = ~w_held & ~s_axi_bvalid;
wire aw_now = aw_held | s_axi_awvalid;
wire w_now = w_held | s_axi_wvalid;
wire [7:0] wa = aw_held ? aw_addr_reg : s_axi_awaddr;
wire [31:0] wd = w_held ? w_data_reg : s_axi_wdata;
wire [3:0] ws = w_held ? w_strb_reg : s_axi_wstrb;
wire wr_go = aw_now & w_now & ~s_axi_bvalid;
integer bi;
always @(posedge core_clk_i)
begin
  if (!rst_n_i)
  begin
    aw_held <= 1'b0;
    w_held <= 1'b0;
    aw_addr_reg <= 8'h00;
    w_data_reg <= 32'h0000_0000;
    w_strb_reg <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= 2'h0;
    ctrl_reg <= `DUD_CTRL_RST;
  end
  else
  begin
    if (s_axi_awvalid && s_axi_awready && !wr_go)
    begin
      aw_held <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready && !wr_go)
    begin
      w_held <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
    if (wr_go)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_bvalid <= 1'b1;
      if (wa[7:2] == `DUD_REG_CTRL >> 2)
      begin
        s_axi_bresp <= 2'h0;
        for (bi = 0; bi < 4; bi = bi + 1)
        begin
          if (ws[bi])
          begin
            ctrl_reg[bi*8 +: 8] <= wd[bi*8 +: 8];
          end
        end
      end
      else
      begin
        s_axi_bresp <= 2'h2;
      end
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end
end

// Read path: one-cycle answer
assign s_axi_arready = ~s_axi_rvalid;
always @(posedge core_clk_i)
begin
  if (!rst_n_i)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h0000_0000;
    s_axi_rresp <= 2'h0;
  end
  else if (s_axi_arvalid && s_axi_arready)
  begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp <= 2'h0;
    case (s_axi_araddr[7:2])
      `DUD_REG_INSN >> 2: s_axi_rdata <= last_insn_reg;
      `DUD_REG_CTRL >> 2: s_axi_rdata <= ctrl_reg;
      `DUD_REG_FIELDS >> 2: s_axi_rdata <= {17'h0_0000, cond_sel_o, zero_test_o,
        dec_format_o, side_b_o, cross_path_o, second_data_unit_o,
        parallel_o, illegal_o, base_wb_o, route_ok_o, execute_o};
      `DUD_REG_STATUS >> 2: s_axi_rdata <= illegal_cnt_reg;
      `DUD_REG_ADDR >> 2: s_axi_rdata <= decode_cnt_reg;
      default:
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'h2;
      end
    endcase
  end
  else if (s_axi_rvalid && s_axi_rready)
  begin
    s_axi_rvalid <= 1'b0;
  end
end

endmodule // dud_decoder

// ### testbench/dud_decoder_assertions.sv
// Checker for the data unit opcode decoder: field pick-up and address rules.
// Assumes one clock, synchronous active-low reset, outputs one cycle after input.
`timescale 1ns/100ps
module dud_decoder_checker
#(
  parameter ADDR_W = 32
)
(
  input wire core_clk_i,
  input wire rst_n_i,
  input wire insn_valid_i,
  input wire [31:0] insn_i,
  input wire [ADDR_W-1:0] base_value_i,
  input wire [2:0] dec_format_o,
  input wire [2:0] cond_sel_o,
  input wire zero_test_o,
  input wire parallel_o,
  input wire side_b_o,
  input wire cross_path_o,
  input wire second_data_unit_o,
  input wire illegal_o,
  input wire [ADDR_W-1:0] mem_addr_o,
  input wire base_wb_o,
  input wire s_axi_bvalid
);
  // Basic load/store word presented this cycle
  wire ls = insn_valid_i && insn_i[3:2] == 2'h1;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  a_par_chain: assert property (insn_valid_i |=> parallel_o == $past(insn_i[0]))
    else $error("parallel flag off");
  a_cond_pick: assert property (insn_valid_i |=>
    {cond_sel_o, zero_test_o} == $past(insn_i[31:28]))
    else $error("condition fields off");
  a_side_pick: assert property (insn_valid_i |=> side_b_o == $past(insn_i[1]))
    else $error("side bit off");
  a_unit_steer: assert property (ls |=>
    second_data_unit_o == $past(insn_i[7]) && dec_format_o == 3'h1)
    else $error("unit select off");
  a_const_add: assert property (ls && insn_i[12:9] == 4'h1 |=>
    mem_addr_o == $past(base_value_i) + $past(insn_i[17:13]))
    else $error("offset address off");
  a_no_update: assert property (ls && !insn_i[12] |=> !base_wb_o)
    else $error("write-back on plain offset");
  a_mod_update: assert property (ls && insn_i[12] |=> base_wb_o)
    else $error("no write-back on modify");
  a_reserved_mode: assert property (ls && !insn_i[12] && insn_i[10] |=>
    illegal_o && !base_wb_o && mem_addr_o == $past(base_value_i))
    else $error("reserved mode accepted");
  a_long_refuse: assert property (insn_valid_i && insn_i[3:2] == 2'h3 |=>
    dec_format_o == 3'h2 && illegal_o == !$past(insn_i[7]))
    else $error("long form unit rule off");
  a_dbasic_fmt: assert property (insn_valid_i && insn_i[6:2] == 5'h10 |=>
    dec_format_o == 3'h3)
    else $error("data unit format off");
  a_ext_format: assert property (insn_valid_i && insn_i[5:2] == 4'hC |=>
    dec_format_o == 3'h4 && cross_path_o == $past(insn_i[12])
    && illegal_o == ($past(insn_i[11:10]) != 2'h2))
    else $error("extended format off");
  c_modify: cover property (ls && insn_i[12]);
  c_illegal: cover property (illegal_o);
  c_write_resp: cover property (s_axi_bvalid);
endmodule // dud_decoder_checker

bind dud_decoder dud_decoder_checker #(.ADDR_W(ADDR_W)) u_dud_decoder_checker (
  .core_clk_i, .rst_n_i, .insn_valid_i, .insn_i, .base_value_i, .dec_format_o, .cond_sel_o,
  .zero_test_o, .parallel_o, .side_b_o, .cross_path_o, .second_data_unit_o, .illegal_o,
  .mem_addr_o, .base_wb_o, .s_axi_bvalid);

// ### testbench/dud_fetch_model.sv
// Fetch and dispatch stage model: hands one word per cycle to the decoder.
// Assumes the bench asks for a word one cycle ahead of its issue.
`timescale 1ns/100ps
module dud_fetch_model
(
  input wire core_clk_i,
  input wire rst_n_i,
  input wire issue_i,
  input wire [31:0] word_i,
  output reg insn_valid_o,
  output reg [31:0] insn_o
);
  initial insn_o = 32'h0;
  // Idle cycles show a changing pattern, not the last word
  always @(posedge core_clk_i)
  begin
    insn_valid_o <= rst_n_i && issue_i;
    insn_o <= (rst_n_i && issue_i) ? word_i : ~insn_o;
  end
endmodule // dud_fetch_model

// ### testbench/dud_decoder_bench.sv
// Self-checking bench for the data unit opcode decoder and its register slave.
// Assumes the decoder answers one cycle after each word and an AXI4-Lite master here.
`timescale 1ns/100ps
module dud_decoder_bench;
  logic core_clk_i, rst_n_i, insn_valid_i, enhanced_i, issue, dec_valid_o, zero_test_o;
  logic execute_o, parallel_o, side_b_o, cross_path_o, second_data_unit_o, doubleword_o;
  logic illegal_o, base_wb_o, route_ok_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, pend, ls_w, exp_wb, force_enh;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] dec_format_o, cond_sel_o;
  logic [3:0] s_axi_wstrb;
  logic [4:0] dest_reg_o, pointer_reg_field_o, index_reg_field_o, class_i;
  logic [5:0] operation_field_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] insn_i, word, pred_value_i, base_value_i, index_value_i, mem_addr_o, d, last_w;
  logic [31:0] base_wb_value_o, s_axi_wdata, s_axi_rdata;
  logic [22:0] exp_f;
  logic [63:0] exp_a;
  integer seed = 32'hb5b0, mismatches = 0, check_count = 0, n_dec = 0, n_ill = 0, n_frz = 0;

  dud_fetch_model u_dud_fetch_model (.core_clk_i, .rst_n_i, .issue_i(issue), .word_i(word),
    .insn_valid_o(insn_valid_i), .insn_o(insn_i));
  dud_decoder u_dud_decoder (.core_clk_i, .rst_n_i, .insn_valid_i, .insn_i, .enhanced_i,
    .pred_value_i, .base_value_i, .index_value_i, .dec_valid_o, .dec_format_o, .cond_sel_o,
    .zero_test_o, .execute_o, .parallel_o, .side_b_o, .cross_path_o, .second_data_unit_o,
    .operation_field_o, .dest_reg_o, .pointer_reg_field_o, .index_reg_field_o, .doubleword_o,
    .illegal_o, .mem_addr_o, .base_wb_o, .base_wb_value_o, .class_i, .route_ok_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // Clock at 25 MHz
  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////
  // Word of format k: 0 basic load/store, 1 long, 2 basic data, 3 extended data
  function [31:0] mk(input [1:0] k, input [31:0] w);
    begin
      mk = w;
      case (k)
        2'h0: mk[3:2] = 2'h1;
        2'h1: mk[3:2] = 2'h3;
        2'h2: mk[6:2] = 5'h10;
        default: mk[5:2] = 4'hC;
      endcase
      if (mk[31:29] == 3'h0) mk[28] = 1'b0;
    end
  endfunction
  // Expected {valid, format, cond, z, p, s, x, y, op, dw, illegal, wb, execute, route}
  function [22:0] fld_calc(input [31:0] w, input [31:0] pr, input [4:0] c, input e);
    reg ls, lg, db, ex, ill, ok;
    reg [5:0] op;
    begin
      ls = w[3:2] == 2'h1;
      lg = w[3:2] == 2'h3;
      db = w[6:2] == 5'h10;
      ex = w[5:2] == 4'hC;
      op = db ? w[12:7] : ex ? {2'h0, w[9:6]} : {3'h0, w[6:4]};
      ill = (ls && !w[12] && w[10]) || (lg && !w[7]) || (ex && w[11:10] != 2'h2);
      ok = c[3:0] == 4'h5 ? e : c[3:0] < 4'h5 ? c[4] : 1'b1;
      fld_calc = {1'b1, ls ? 3'h1 : lg ? 3'h2 : db ? 3'h3 : 3'h4, w[31:28], w[0], w[1],
        ex & w[12], w[2] & w[7], op, ls & w[8], ill, ls & w[12],
        !ill && (w[31:29] == 3'h0 || (w[28] ^ pr[w[31:29]])), ok};
    end
  endfunction
  // Expected {write-back value, address}
  function [63:0] addr_calc(input [31:0] w, input [31:0] b, input [31:0] i);
    reg [31:0] off, sum;
    begin
      off = w[11] ? i : {27'h0, w[17:13]};
      sum = w[9] ? b + off : b - off;
      if (w[3:2] == 2'h3) addr_calc = {sum, b + {17'h0, w[22:8]}};
      else addr_calc = {sum, w[10] ? b : sum};
    end
  endfunction
  task check_val(input [63:0] got, input [63:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  ////////////////////////////////////////
  // Compare last cycle's word, then capture the word now at the pins
  always @(negedge core_clk_i)
  begin
    if (pend)
    begin
      check_val({9'h0, dec_valid_o, dec_format_o, cond_sel_o, zero_test_o, parallel_o,
        side_b_o, cross_path_o, second_data_unit_o & ls_w, operation_field_o, doubleword_o,
        illegal_o, base_wb_o, execute_o, route_ok_o},
        {9'h0, exp_f});
      if (ls_w) check_val(mem_addr_o, exp_a[31:0]);
      if (exp_wb) check_val(base_wb_value_o, exp_a[63:32]);
      if (last_w[3:2] == 2'h1) check_val({17'h0, dest_reg_o, pointer_reg_field_o,
        index_reg_field_o}, {17'h0, last_w[27:13]});
    end
    pend = insn_valid_i === 1'b1;
    if (pend)
    begin
      last_w = insn_i;
      ls_w = insn_i[2];
      exp_f = fld_calc(insn_i, pred_value_i, class_i, enhanced_i | force_enh);
      exp_a = addr_calc(insn_i, base_value_i, index_value_i);
      exp_wb = insn_i[3:2] == 2'h1 && insn_i[12];
      n_dec = n_dec + 1;
      n_ill = n_ill + exp_f[3];
    end
  end
  // Every mode code and both long units first, then random words with gaps
  task run(input integer n);
    integer i;
    reg [31:0] w;
    begin
      for (i = 0; i < n; i = i + 1)
      begin
        w = mk(i < 16 ? 2'h0 : i < 18 ? 2'h1 : $random(seed), $random(seed));
        if (i < 16) w[12:9] = i[3:0];
        if (i < 18) w[7] = i[0];
        @(posedge core_clk_i);
        issue <= i < 18 || $random(seed) % 4 != 0;
        word <= w;
        base_value_i <= i % 3 == 0 ? 32'hFFFF_FFFF : i % 3 == 1 ? 32'h0 : $random(seed);
        index_value_i <= $random(seed);
        pred_value_i <= $random(seed);
        class_i <= ({$random(seed)} % 8) + 1 + ($random(seed) & 16);
        enhanced_i <= $random(seed);
      end
      @(posedge core_clk_i);
      issue <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      $display("decode run of %0d words done", n);
    end
  endtask
  task axi_wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge core_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge core_clk_i);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task axi_rd(input [7:0] a);
    begin
      @(posedge core_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge core_clk_i);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge core_clk_i);
    mismatches = mismatches + 1;
    stop_test;
  end
  // Main sequence: decode, register access, decode with forced enhanced routing
  initial
  begin
    {rst_n_i, issue, word, enhanced_i, pred_value_i, base_value_i, index_value_i} = 0;
    {class_i, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, pend, force_enh} = 0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    axi_rd(8'h04);
    check_val({r, d}, 34'h0);
    run(300);
    axi_rd(8'h10);
    check_val(d, n_dec);
    axi_rd(8'h0C);
    check_val(d, n_ill);
    axi_rd(8'h00);
    check_val(d, last_w);
    axi_rd(8'h08);
    check_val({d[31:15], d[3:2], d[0]}, 20'h0);
    axi_wr(8'h04, 32'h3);
    check_val(r, 2'h0);
    axi_wr(8'h00, 32'h5A);
    check_val(r, 2'h2);
    axi_rd(8'h14);
    check_val({r, d}, {2'h2, 32'h0});
    axi_rd(8'h04);
    check_val({r, d}, {2'h0, 32'h3});
    $display("register test done");
    force_enh = 1'b1;
    n_frz = n_dec;
    run(200);
    axi_rd(8'h10);
    check_val(d, n_frz);
    stop_test;
  end
endmodule // dud_decoder_bench
